/* File: rtl/vcl_pkg.sv */
// Shared constants for the video control latches
package vcl_pkg;
  localparam int unsigned WORD_W          = 8;
  localparam int unsigned FILT_W          = 3;
  // Instrument bus write addresses
  localparam logic [7:0]  OFFSET_DAC_ADDR = 8'h78;
  localparam logic [7:0]  MODE_SEL_ADDR   = 8'h79;
  localparam logic [7:0]  VPROC_CTRL_ADDR = 8'h7C;
  // Reset values
  localparam logic [7:0]  OFFSET_DAC_RST  = 8'h00;
  localparam logic [7:0]  MODE_SEL_RST    = 8'h00;
  localparam logic [7:0]  VPROC_CTRL_RST  = 8'h40;
  // Mode latch fields
  localparam int unsigned MODE_GAIN_LSB   = 0;
  localparam int unsigned MODE_GAIN_MSB   = 3;
  localparam int unsigned MODE_LIN_BIT    = 4;
  localparam int unsigned MODE_LOG_BIT    = 5;
  localparam int unsigned MODE_IDENT_BIT  = 6;
  localparam int unsigned MODE_STRETCH_BIT = 7;
  // Video processor control word fields
  localparam int unsigned VPC_BAND4_BIT   = 0;
  localparam int unsigned VPC_FILT_LSB    = 1;
  localparam int unsigned VPC_FILT_MSB    = 4;
  localparam int unsigned VPC_SLOPE_BIT   = 6;
  // Filter select codes (bits 4:1) and resulting bandwidth index
  localparam logic [3:0]  FSEL_30K        = 4'h1;
  localparam logic [3:0]  FSEL_3K         = 4'h2;
  localparam logic [3:0]  FSEL_300        = 4'h3;
  localparam logic [3:0]  FSEL_30         = 4'h4;
  localparam logic [3:0]  FSEL_3          = 4'h5;
  localparam logic [3:0]  FSEL_0P3        = 4'h6;
  localparam logic [3:0]  FSEL_NONE       = 4'h0;
  localparam logic [2:0]  FIDX_NONE       = 3'h0;
  localparam logic [2:0]  FIDX_30K        = 3'h1;
  localparam logic [2:0]  FIDX_3K         = 3'h2;
  localparam logic [2:0]  FIDX_300        = 3'h3;
  localparam logic [2:0]  FIDX_30         = 3'h4;
  localparam logic [2:0]  FIDX_3          = 3'h5;
  localparam logic [2:0]  FIDX_0P3        = 3'h6;
endpackage : vcl_pkg

/* File: rtl/vcl_latches.sv */
// Video amplifier and video processor control latches
module vcl_latches #(
  parameter logic [7:0] VPROC_ADDR = vcl_pkg::VPROC_CTRL_ADDR
) (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic [7:0]                  bus_addr_i,
  input  wire logic [vcl_pkg::WORD_W-1:0]  bus_data_i,
  input  wire logic                        bus_wr_i,
  output logic                             gain_load_o,
  output logic                             mode_load_o,
  output logic [vcl_pkg::WORD_W-1:0]       dac_code_o,
  output logic [3:0]                       db_div_gain_o,
  output logic                             lin_path_en_o,
  output logic                             log_path_en_o,
  output logic                             data_bit_six_o,
  output logic                             pulse_stretch_o,
  output logic                             band_four_level_select_o,
  output logic                             slope_corr_en_o,
  output logic [vcl_pkg::FILT_W-1:0]       filter_sel_o,
  output logic                             filter_bypass_o
);
  import vcl_pkg::*;

  logic              rst_s1_q;
  logic              rst_n;
  logic [7:0]        addr_s1_q;
  logic [7:0]        addr_s2_q;
  logic [WORD_W-1:0] data_s1_q;
  logic [WORD_W-1:0] data_s2_q;
  logic              wr_s1_q;
  logic              wr_s2_q;
  logic              wr_s3_q;
  logic              wr_pulse;
  logic [WORD_W-1:0] wdata_q;
  logic              vpc_load_q;
  logic [WORD_W-1:0] mode_q;
  logic [WORD_W-1:0] vpc_q;
  logic [FILT_W-1:0] fidx_d;

  // Checks below share one clock and the synchronised reset
  default clocking vcl_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  // Reset release synchroniser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Address and data pins pass two flip-flops, the write line three
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_s1_q <= 8'h00;
      addr_s2_q <= 8'h00;
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
      wr_s1_q   <= 1'b0;
      wr_s2_q   <= 1'b0;
      wr_s3_q   <= 1'b0;
    end else begin
      addr_s1_q <= bus_addr_i;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= bus_data_i;
      data_s2_q <= data_s1_q;
      wr_s1_q   <= bus_wr_i;
      wr_s2_q   <= wr_s1_q;
      wr_s3_q   <= wr_s2_q;
    end
  end

  assign wr_pulse = wr_s2_q & ~wr_s3_q;

  // Address decode into load strobes
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gain_load_o <= 1'b0;
      mode_load_o <= 1'b0;
      vpc_load_q  <= 1'b0;
      wdata_q     <= 8'h00;
    end else begin
      gain_load_o <= wr_pulse && (addr_s2_q == OFFSET_DAC_ADDR);
      mode_load_o <= wr_pulse && (addr_s2_q == MODE_SEL_ADDR);
      vpc_load_q  <= wr_pulse && (addr_s2_q == VPROC_ADDR);
      if (wr_pulse) begin
        wdata_q <= data_s2_q;
      end
    end
  end

  // Gain latch feeds the offset DAC
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dac_code_o <= OFFSET_DAC_RST;
    end else if (gain_load_o) begin
      dac_code_o <= wdata_q;
    end
  end

  // Mode latch
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_SEL_RST;
    end else if (mode_load_o) begin
      mode_q <= wdata_q;
    end
  end

  // Video processor control word
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vpc_q <= VPROC_CTRL_RST;
    end else if (vpc_load_q) begin
      vpc_q <= wdata_q;
    end
  end

  // Mode fields onto their controls
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      db_div_gain_o   <= MODE_SEL_RST[MODE_GAIN_MSB:MODE_GAIN_LSB];
      lin_path_en_o   <= MODE_SEL_RST[MODE_LIN_BIT];
      log_path_en_o   <= MODE_SEL_RST[MODE_LOG_BIT];
      data_bit_six_o  <= MODE_SEL_RST[MODE_IDENT_BIT];
      pulse_stretch_o <= MODE_SEL_RST[MODE_STRETCH_BIT];
    end else begin
      db_div_gain_o   <= mode_q[MODE_GAIN_MSB:MODE_GAIN_LSB];
      lin_path_en_o   <= mode_q[MODE_LIN_BIT];
      log_path_en_o   <= mode_q[MODE_LOG_BIT];
      data_bit_six_o  <= mode_q[MODE_IDENT_BIT];
      pulse_stretch_o <= mode_q[MODE_STRETCH_BIT];
    end
  end

  // Filter code to bandwidth index
  always_comb begin
    unique case (vpc_q[VPC_FILT_MSB:VPC_FILT_LSB])
      FSEL_30K: fidx_d = FIDX_30K;
      FSEL_3K:  fidx_d = FIDX_3K;
      FSEL_300: fidx_d = FIDX_300;
      FSEL_30:  fidx_d = FIDX_30;
      FSEL_3:   fidx_d = FIDX_3;
      FSEL_0P3: fidx_d = FIDX_0P3;
      default:  fidx_d = FIDX_NONE;
    endcase
  end

  // Video processor controls
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      band_four_level_select_o <= VPROC_CTRL_RST[VPC_BAND4_BIT];
      slope_corr_en_o          <= ~VPROC_CTRL_RST[VPC_SLOPE_BIT];
      filter_sel_o             <= FIDX_NONE;
      filter_bypass_o          <= 1'b1;
    end else begin
      band_four_level_select_o <= vpc_q[VPC_BAND4_BIT];
      slope_corr_en_o          <= ~vpc_q[VPC_SLOPE_BIT];
      filter_sel_o             <= fidx_d;
      filter_bypass_o          <= (fidx_d == FIDX_NONE);
    end
  end

  // Checks
  gain_strobe_a: assert property (
    wr_pulse && addr_s2_q == OFFSET_DAC_ADDR |=> gain_load_o && !mode_load_o)
    else $error("gain strobe missing");
  mode_strobe_a: assert property (
    wr_pulse && addr_s2_q == MODE_SEL_ADDR |=> mode_load_o && !gain_load_o)
    else $error("mode strobe missing");
  dac_capture_a: assert property (
    gain_load_o |=> dac_code_o == $past(wdata_q))
    else $error("dac code not captured");
  dac_hold_a: assert property (
    !gain_load_o |=> $stable(dac_code_o))
    else $error("dac code changed without write");
  mode_gain_a: assert property (
    mode_load_o |=> ##1
      db_div_gain_o == $past(wdata_q[MODE_GAIN_MSB:MODE_GAIN_LSB], 2))
    else $error("gain code wrong");
  mode_paths_a: assert property (
    mode_load_o |=> ##1 lin_path_en_o == $past(wdata_q[MODE_LIN_BIT], 2)
      && log_path_en_o == $past(wdata_q[MODE_LOG_BIT], 2)
      && data_bit_six_o == $past(wdata_q[MODE_IDENT_BIT], 2))
    else $error("mode path enables wrong");
  stretch_sel_a: assert property (
    mode_load_o |=> ##1
      pulse_stretch_o == $past(wdata_q[MODE_STRETCH_BIT], 2))
    else $error("pulse stretch wrong");
  band4_route_a: assert property (
    vpc_q[VPC_BAND4_BIT] |=> band_four_level_select_o)
    else $error("band 4 leveling not routed");
  slope_enable_a: assert property (
    !vpc_q[VPC_SLOPE_BIT] |=> slope_corr_en_o)
    else $error("slope correction not enabled");
  filter_range_a: assert property (
    vpc_q[VPC_FILT_MSB:VPC_FILT_LSB] == FSEL_300
      |=> filter_sel_o == FIDX_300 && !filter_bypass_o)
    else $error("filter select wrong");
  filter_none_a: assert property (
    vpc_q[VPC_FILT_MSB:VPC_FILT_LSB] == FSEL_NONE
      |=> filter_bypass_o && filter_sel_o == FIDX_NONE)
    else $error("bypass not applied");
  gain_write_c: cover property (gain_load_o);
  mode_write_c: cover property (mode_load_o ##2 pulse_stretch_o);
  vpc_write_c: cover property (vpc_load_q ##2 slope_corr_en_o);
endmodule : vcl_latches

/* File: tb/vcl_host_model.sv */
// Instrument microcomputer model writing the analyzer data bus
module vcl_host_model (
  input  wire logic       clk_i,
  output logic      [7:0] bus_addr_o,
  output logic      [7:0] bus_data_o,
  output logic            bus_wr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    bus_addr_o = 8'h00;
    bus_data_o = 8'h00;
    bus_wr_o   = 1'b0;
  end
  // One write: setup, strobe, hold, then release the bus
  task automatic write_word(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    bus_addr_o = a;
    bus_data_o = d;
    @(negedge clk_i);
    bus_wr_o = 1'b1;
    repeat (4) @(negedge clk_i);
    bus_wr_o = 1'b0;
    repeat (3) @(negedge clk_i);
    // Released lines show the inverse, not the last value
    bus_addr_o = ~a;
    bus_data_o = ~d;
    repeat (2) @(negedge clk_i);
  endtask : write_word
endmodule : vcl_host_model

/* File: tb/video_control_latches_bench.sv */
// Self-checking bench for the video control latches
module video_control_latches_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import vcl_pkg::*;
  logic       clk, resetn, wr, gl, ml, lin, lg, ident, st, b4, slope, byp;
  logic [7:0] addr, data, dac;
  logic [3:0] dbg;
  logic [2:0] fsel;
  logic [7:0] last_m, last_c;
  int         fails, samples_checked, gcnt, mcnt;
  vcl_host_model host (.clk_i(clk), .bus_addr_o(addr), .bus_data_o(data),
                       .bus_wr_o(wr));
  vcl_latches DUT (.clk_i(clk), .resetn_i(resetn), .bus_addr_i(addr),
    .bus_data_i(data), .bus_wr_i(wr), .gain_load_o(gl), .mode_load_o(ml),
    .dac_code_o(dac), .db_div_gain_o(dbg), .lin_path_en_o(lin),
    .log_path_en_o(lg), .data_bit_six_o(ident), .pulse_stretch_o(st),
    .band_four_level_select_o(b4), .slope_corr_en_o(slope),
    .filter_sel_o(fsel), .filter_bypass_o(byp));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Count load pulses mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (gl === 1'b1) gcnt++;
    if (ml === 1'b1) mcnt++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  task automatic chk_mode(input logic [7:0] m);
    chk("mode", m, {st, ident, lg, lin, dbg});
  endtask : chk_mode
  task automatic chk_ctrl(input logic [7:0] c);
    logic [2:0] idx;
    idx = (c[4:1] >= 4'h1 && c[4:1] <= 4'h6) ? c[3:1] : FIDX_NONE;
    chk("band_slope", {6'h00, c[0], ~c[6]}, {6'h00, b4, slope});
    chk("filter", {4'h0, idx, idx == FIDX_NONE}, {4'h0, fsel, byp});
  endtask : chk_ctrl
  task automatic chk_counts(input int eg, input int em);
    chk("gain_loads", 8'(eg), 8'(gcnt));
    chk("mode_loads", 8'(em), 8'(mcnt));
  endtask : chk_counts
  task automatic t_reset;
    chk("dac", OFFSET_DAC_RST, dac);
    chk_mode(MODE_SEL_RST);
    chk_ctrl(VPROC_CTRL_RST);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_gain;
    host.write_word(OFFSET_DAC_ADDR, 8'hA5);
    chk("dac", 8'hA5, dac);
    chk_counts(1, 0);
    host.write_word(MODE_SEL_ADDR, 8'h9A);
    chk("dac_hold", 8'hA5, dac);
    chk_mode(8'h9A);
    chk_counts(1, 1);
    $display("t_gain done");
  endtask : t_gain
  task automatic t_mode;
    logic [7:0] vals [4];
    vals = '{8'h65, 8'hFF, 8'h0F, 8'h80};
    foreach (vals[i]) begin
      host.write_word(MODE_SEL_ADDR, vals[i]);
      chk_mode(vals[i]);
    end
    chk_counts(1, 5);
    last_m = 8'h80;
    $display("t_mode done");
  endtask : t_mode
  task automatic t_ctrl;
    logic [3:0] f;
    logic [7:0] c;
    for (int k = 0; k < 9; k++) begin
      f = (k == 8) ? 4'hF : 4'(k);
      c = {1'b0, k[1], 1'b0, f, k[0]};
      host.write_word(VPROC_CTRL_ADDR, c);
      chk_ctrl(c);
      last_c = c;
    end
    chk_counts(1, 5);
    chk("dac_hold", 8'hA5, dac);
    $display("t_ctrl done");
  endtask : t_ctrl
  task automatic t_unmapped;
    host.write_word(8'h77, 8'h3C);
    host.write_word(8'h7A, 8'hC3);
    chk_counts(1, 5);
    chk("dac_hold", 8'hA5, dac);
    chk_mode(last_m);
    chk_ctrl(last_c);
    $display("t_unmapped done");
  endtask : t_unmapped
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    resetn = 1'b0;
    fails = 0;
    samples_checked = 0;
    gcnt = 0;
    mcnt = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_gain();
    t_mode();
    t_ctrl();
    t_unmapped();
    tally_and_finish();
  end
endmodule : video_control_latches_bench
